// file: astx_map.svh
// Register offsets, field positions, reset values and timing counts
// of the serial transmitter. Included by the module and the testbench.
`ifndef ASTX_MAP_SVH
`define ASTX_MAP_SVH

// Byte offsets on the APB (one aligned word each)
`define ASTX_OFF_BAUD_HIGH   8'h00
`define ASTX_OFF_BAUD_LOW    8'h04
`define ASTX_OFF_FRAME_CFG   8'h08
`define ASTX_OFF_ENABLE_CFG  8'h0C
`define ASTX_OFF_STATUS_ONE  8'h10
`define ASTX_OFF_BUF_HIGH    8'h14
`define ASTX_OFF_BUF_LOW     8'h18

// Field positions
`define ASTX_BIT_LONG_WORD   4
`define ASTX_BIT_PARITY_ON   1
`define ASTX_BIT_PARITY_KIND 0
`define ASTX_BIT_TX_IRQ_EN   7
`define ASTX_BIT_RX_IRQ_EN   5
`define ASTX_BIT_TX_ON       3
`define ASTX_BIT_TX_EMPTY    7
`define ASTX_BIT_RX_FULL     5
`define ASTX_BIT_NINTH       6

// Reset values and timing
`define ASTX_RST_TX_EMPTY    1'b1
`define ASTX_RST_DIVISOR     13'h0000
`define ASTX_SUBTICKS        5'h10
`define ASTX_LOAD_SUBTICK    4'h8
`define ASTX_LAST_SHORT      4'h9
`define ASTX_LAST_LONG       4'hA

`endif

// file: astx_pkg.sv
// Types shared by the serial transmitter.
// Assumes astx_map.svh is on the include path.
`default_nettype none

package astx_pkg;

	// Frame options written by software
	typedef struct packed {
		logic long_word;
		logic parity_on;
		logic parity_kind;
	} astx_cfg_t;

	// Enables written by software
	typedef struct packed {
		logic tx_empty_irq_enable;
		logic rx_full_irq_enable;
		logic tx_on;
	} astx_ena_t;

	// Transmitter sequencing
	typedef enum logic [1:0] {
		ASTX_OFF,
		ASTX_IDLE,
		ASTX_SEND
	} astx_state_t;

endpackage

`default_nettype wire

// file: astx_tx.sv
// Asynchronous serial transmitter with double-buffered data, APB slave.
// Assumes one 25 MHz clock, synchronous reset, and that the receive-full
// level comes from receive logic on the same clock.
//
// Function
// - Moving buffer into shifter sets the transmit-empty flag.
// - Buffer moves nine sixteenths into the previous stop bit.
// - Enabling transmitter loads ten or eleven ones as preamble.
// - Buffered data moves only after the preamble has shifted out.
// - Frame has low start bit at LSB, high stop bit at MSB.
// - Odd or even parity replaces the top data bit when enabled.
// - Empty flag with its enable raises the transmit request.
// - Baud generator stands still while the divisor is zero.
// - High divisor byte waits for the low byte write.
// - Transmit-empty flag is one after reset.
// - No new frame starts until software clears the empty flag.
// - Receive-full flag with its enable raises the receive request.
// - Buffer accepts new data while the shifter is still sending.
//
// Added by the designer: the APB register port and the register offsets.
`include "astx_map.svh"
`default_nettype none

module astx_tx #(
	parameter int DIV_W = 13
) (
	input  wire logic        mclk_i,     // Bus clock
	input  wire logic        rst_i,      // Synchronous reset
	input  wire logic        psel_i,     // APB select
	input  wire logic        penable_i,  // APB access phase
	input  wire logic        pwrite_i,   // APB direction
	input  wire logic [7:0]  paddr_i,    // APB byte address
	input  wire logic [31:0] pwdata_i,   // APB write data
	output logic      [31:0] prdata_o,   // APB read data
	output logic             pready_o,   // APB ready
	output logic             pslverr_o,  // APB error
	input  wire logic        rx_full_i,  // Receive-full level
	output logic             txd_o,      // Serial line
	output logic             tx_irq_o,   // Transmit request
	output logic             rx_irq_o    // Receive request
);

	if (DIV_W < 9 || DIV_W > 16) begin : g_chk
		$error("DIV_W must lie between 9 and 16");
	end

	localparam int HI_W = DIV_W - 8;

	// State registers
	astx_pkg::astx_state_t st, next_st;
	astx_pkg::astx_cfg_t   cfg, next_cfg;
	astx_pkg::astx_ena_t   ena, next_ena;
	logic [10:0]      shreg, next_shreg;
	logic [10:0]      pend, next_pend;
	logic             pend_v, next_pend_v;
	logic [3:0]       bitn, next_bitn;
	logic [3:0]       rt, next_rt;
	logic             in_pre, next_in_pre;
	logic             flag, next_flag;
	logic             armed, next_armed;
	logic             txd, next_txd;
	logic [DIV_W-1:0] div, next_div;
	logic [DIV_W-1:0] baud_cnt, next_baud_cnt;
	logic [HI_W-1:0]  div_hi, next_div_hi;
	logic [7:0]       d_lo, next_d_lo;
	logic             ninth, next_ninth;
	logic [31:0]      rdata, next_rdata;
	logic             serr, next_serr;

	// Decoded strobes
	logic        acc, setup, wr, rd;
	logic        rt_tick, load_pend, load_now;
	logic [3:0]  last;
	logic [10:0] frame;

	// Build one framed word from the buffer and options
	function automatic logic [10:0] frame_of(
		input astx_pkg::astx_cfg_t c,
		input logic [8:0]          d
	);
		logic p8;
		logic p7;
		p8 = (^d[7:0]) ^ c.parity_kind;
		p7 = (^d[6:0]) ^ c.parity_kind;
		if (c.long_word) begin
			frame_of = {1'b1, c.parity_on ? p8 : d[8], d[7:0], 1'b0};
		end else begin
			frame_of = {2'b11, c.parity_on ? p7 : d[7], d[6:0], 1'b0};
		end
	endfunction

	// Bus phase decode, zero-wait slave
	assign setup    = psel_i & ~penable_i;
	assign acc      = psel_i & penable_i;
	assign wr       = acc & pwrite_i;
	assign rd       = acc & ~pwrite_i;
	assign pready_o = 1'b1;
	assign prdata_o = rdata;
	assign pslverr_o = serr & acc;

	// Request outputs
	// transmit request gating
	assign tx_irq_o = flag & ena.tx_empty_irq_enable;
	assign rx_irq_o = rx_full_i & ena.rx_full_irq_enable;
	assign txd_o    = txd;

	// Frame length and framed buffer contents
	// start and stop placement
	assign last  = cfg.long_word ? `ASTX_LAST_LONG : `ASTX_LAST_SHORT;
	assign frame = frame_of(cfg, {ninth, d_lo});

	// Register file next values
	always_comb begin
		next_div    = div;
		next_div_hi = div_hi;
		next_cfg    = cfg;
		next_ena    = ena;
		next_d_lo   = d_lo;
		next_ninth  = ninth;
		next_rdata  = rdata;
		next_serr   = serr;
		next_armed  = armed;
		if (wr) begin
			unique case (paddr_i)
				`ASTX_OFF_BAUD_HIGH: begin
					next_div_hi = pwdata_i[HI_W-1:0];
				end
				`ASTX_OFF_BAUD_LOW: begin
					next_div = {div_hi, pwdata_i[7:0]};
				end
				`ASTX_OFF_FRAME_CFG: begin
					next_cfg.long_word   = pwdata_i[`ASTX_BIT_LONG_WORD];
					next_cfg.parity_on   = pwdata_i[`ASTX_BIT_PARITY_ON];
					next_cfg.parity_kind = pwdata_i[`ASTX_BIT_PARITY_KIND];
				end
				`ASTX_OFF_ENABLE_CFG: begin
					next_ena.tx_empty_irq_enable =
						pwdata_i[`ASTX_BIT_TX_IRQ_EN];
					next_ena.rx_full_irq_enable =
						pwdata_i[`ASTX_BIT_RX_IRQ_EN];
					next_ena.tx_on = pwdata_i[`ASTX_BIT_TX_ON];
				end
				`ASTX_OFF_BUF_HIGH: begin
					next_ninth = pwdata_i[`ASTX_BIT_NINTH];
				end
				`ASTX_OFF_BUF_LOW: begin
					next_d_lo  = pwdata_i[7:0];
					next_armed = 1'b0;
				end
				default: begin
					next_armed = armed;
				end
			endcase
		end
		// Status read with flag set arms the clearing write
		if (rd && paddr_i == `ASTX_OFF_STATUS_ONE && flag) begin
			next_armed = 1'b1;
		end
		// Read data and error captured in the setup cycle
		if (setup) begin
			next_rdata = 32'h0000_0000;
			next_serr  = 1'b0;
			unique case (paddr_i)
				`ASTX_OFF_BAUD_HIGH:
					next_rdata[HI_W-1:0] = div[DIV_W-1:8];
				`ASTX_OFF_BAUD_LOW:
					next_rdata[7:0] = div[7:0];
				`ASTX_OFF_FRAME_CFG: begin
					next_rdata[`ASTX_BIT_LONG_WORD]   = cfg.long_word;
					next_rdata[`ASTX_BIT_PARITY_ON]   = cfg.parity_on;
					next_rdata[`ASTX_BIT_PARITY_KIND] = cfg.parity_kind;
				end
				`ASTX_OFF_ENABLE_CFG: begin
					next_rdata[`ASTX_BIT_TX_IRQ_EN] =
						ena.tx_empty_irq_enable;
					next_rdata[`ASTX_BIT_RX_IRQ_EN] =
						ena.rx_full_irq_enable;
					next_rdata[`ASTX_BIT_TX_ON] = ena.tx_on;
				end
				`ASTX_OFF_STATUS_ONE: begin
					next_rdata[`ASTX_BIT_TX_EMPTY] = flag;
					next_rdata[`ASTX_BIT_RX_FULL]  = rx_full_i;
				end
				`ASTX_OFF_BUF_HIGH:
					next_rdata[`ASTX_BIT_NINTH] = ninth;
				`ASTX_OFF_BUF_LOW:
					next_rdata[7:0] = d_lo;
				default:
					next_serr = 1'b1;
			endcase
		end
	end

	// Baud generator: one sub-tick every div clocks, sixteen per bit
	// stopped while divisor is zero
	always_comb begin
		rt_tick       = (div != '0) && (baud_cnt >= div - 1'b1);
		next_baud_cnt = baud_cnt + 1'b1;
		if (div == '0 || rt_tick) begin
			next_baud_cnt = '0;
		end
	end

	// Transmit sequencer next values
	always_comb begin
		next_st     = st;
		next_shreg  = shreg;
		next_pend   = pend;
		next_pend_v = pend_v;
		next_bitn   = bitn;
		next_rt     = rt;
		next_in_pre = in_pre;
		load_pend   = 1'b0;
		load_now    = 1'b0;
		unique case (st)
			astx_pkg::ASTX_OFF: begin
				if (ena.tx_on) begin
					next_st     = astx_pkg::ASTX_SEND;
					next_shreg  = '1;
					next_bitn   = 4'h0;
					next_rt     = 4'h0;
					next_in_pre = 1'b1;
				end
			end
			astx_pkg::ASTX_IDLE: begin
				// wait for software to clear flag
				if (!flag) begin
					load_now   = 1'b1;
					next_st    = astx_pkg::ASTX_SEND;
					next_shreg = frame;
					next_bitn  = 4'h0;
					next_rt    = 4'h0;
				end
			end
			astx_pkg::ASTX_SEND: begin
				if (rt_tick) begin
					next_rt = rt + 4'h1;
					// transfer at 9/16 of stop bit
					if (bitn == last && rt == `ASTX_LOAD_SUBTICK &&
					    !in_pre && !flag && !pend_v) begin
						load_pend   = 1'b1;
						next_pend   = frame;
						next_pend_v = 1'b1;
					end
					// LSB first, one bit per sixteen ticks
					if (rt == 4'hF) begin
						next_shreg = {1'b1, shreg[10:1]};
						next_bitn  = bitn + 4'h1;
						if (bitn == last) begin
							next_in_pre = 1'b0;
							next_bitn   = 4'h0;
							if (pend_v) begin
								next_shreg  = pend;
								next_pend_v = 1'b0;
							end else begin
								next_st = astx_pkg::ASTX_IDLE;
							end
						end
					end
				end
			end
			default: begin
				next_st = astx_pkg::ASTX_OFF;
			end
		endcase
		if (!ena.tx_on) begin
			next_st     = astx_pkg::ASTX_OFF;
			next_pend_v = 1'b0;
			next_in_pre = 1'b0;
		end
		next_txd = (next_st == astx_pkg::ASTX_SEND) ? next_shreg[0] : 1'b1;
	end

	// Empty flag: a set in the clearing cycle wins
	always_comb begin
		next_flag = flag;
		if (wr && paddr_i == `ASTX_OFF_BUF_LOW && armed) begin
			next_flag = 1'b0;
		end
		// set on every transfer to shifter
		if (load_pend || load_now) begin
			next_flag = 1'b1;
		end
	end

	// Register all state
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			st       <= astx_pkg::ASTX_OFF;
			cfg      <= '0;
			ena      <= '0;
			shreg    <= '1;
			pend     <= '1;
			pend_v   <= 1'b0;
			bitn     <= 4'h0;
			rt       <= 4'h0;
			in_pre   <= 1'b0;
			flag     <= `ASTX_RST_TX_EMPTY;
			armed    <= 1'b0;
			txd      <= 1'b1;
			div      <= DIV_W'(`ASTX_RST_DIVISOR);
			baud_cnt <= '0;
			div_hi   <= '0;
			d_lo     <= 8'h00;
			ninth    <= 1'b0;
			rdata    <= 32'h0000_0000;
			serr     <= 1'b0;
		end else begin
			st       <= next_st;
			cfg      <= next_cfg;
			ena      <= next_ena;
			shreg    <= next_shreg;
			pend     <= next_pend;
			pend_v   <= next_pend_v;
			bitn     <= next_bitn;
			rt       <= next_rt;
			in_pre   <= next_in_pre;
			flag     <= next_flag;
			armed    <= next_armed;
			txd      <= next_txd;
			div      <= next_div;
			baud_cnt <= next_baud_cnt;
			div_hi   <= next_div_hi;
			d_lo     <= next_d_lo;
			ninth    <= next_ninth;
			rdata    <= next_rdata;
			serr     <= next_serr;
		end
	end

	// Checks on the sequencer and register file
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	a_flag_on_load: assert property (
		(load_pend || load_now) |=> flag) else $error("flag not set");
	a_load_timing: assert property (
		load_pend |-> (st == astx_pkg::ASTX_SEND && rt_tick &&
		rt == `ASTX_LOAD_SUBTICK && bitn == last))
		else $error("buffer moved at wrong time");
	a_preamble_ones: assert property (
		(st == astx_pkg::ASTX_OFF && ena.tx_on) |=>
		(st == astx_pkg::ASTX_SEND && in_pre && shreg == 11'h7FF))
		else $error("preamble not loaded");
	a_pre_no_load: assert property (
		in_pre |-> !load_pend) else $error("load during preamble");
	a_frame_ends: assert property (
		load_now |=> (shreg[0] == 1'b0 && shreg[last] == 1'b1))
		else $error("start or stop bit wrong");
	a_parity_long: assert property (
		(load_now && cfg.parity_on && cfg.long_word) |=>
		((^shreg[9:1]) == $past(cfg.parity_kind)))
		else $error("parity bit wrong");
	a_tx_request: assert property (
		$rose(flag) && ena.tx_empty_irq_enable |-> tx_irq_o)
		else $error("transmit request missing");
	a_baud_stopped: assert property (
		(div == '0) [*2] |-> (baud_cnt == '0 && !rt_tick))
		else $error("baud runs with zero divisor");
	a_high_deferred: assert property (
		(wr && paddr_i == `ASTX_OFF_BAUD_HIGH) |=> div == $past(div))
		else $error("high byte took effect early");
	a_reset_flag: assert property (
		$past(rst_i) |-> flag) else $error("flag not one after reset");
	a_hold_full: assert property (
		(st == astx_pkg::ASTX_IDLE && flag) |=>
		st != astx_pkg::ASTX_SEND) else $error("frame without data");
	a_rx_request: assert property (
		rx_irq_o == (rx_full_i && ena.rx_full_irq_enable))
		else $error("receive request wrong");
	a_line_shift: assert property (
		(st == astx_pkg::ASTX_SEND && rt_tick && rt == 4'hF &&
		bitn != last && ena.tx_on) |=> txd_o == $past(shreg[1]))
		else $error("line bit out of order");

	c_preamble_end: cover property (in_pre ##1 !in_pre && ena.tx_on);
	c_buffered: cover property (load_pend);
	c_parity_frame: cover property (load_now && cfg.parity_on);

endmodule

`default_nettype wire

// file: astx_rx_model.sv
// Behavioural serial receiver standing on the transmit line.
// Assumes its divisor and word length match those of the transmitter.
`default_nettype none

module astx_rx_model (
	input  wire logic        mclk_i,   // Bus clock
	input  wire logic        rst_i,    // Synchronous reset
	input  wire logic        line_i,   // Serial line
	input  wire logic [12:0] div_i,    // Baud divisor
	input  wire logic        long_i,   // Long word format
	output logic      [8:0]  word_o,   // Bits between start and stop
	output logic             stop_o,   // Sampled stop bit
	output logic      [15:0] frames_o  // Frames received
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [8:0] w;
	int         n;

	// Nothing received yet
	initial begin
		word_o = 9'h000;
		stop_o = 1'b0;
		frames_o = 16'h0000;
	end

	// Find a start edge, then sample each bit in its middle
	always begin
		do @(posedge mclk_i); while (rst_i || line_i !== 1'b0);
		w = 9'h000;
		n = long_i ? 9 : 8;
		repeat (8 * div_i) @(posedge mclk_i);
		for (int i = 0; i < n; i++) begin
			repeat (16 * div_i) @(posedge mclk_i);
			w[i] = line_i;
		end
		repeat (16 * div_i) @(posedge mclk_i);
		stop_o = line_i;
		word_o = w;
		frames_o = frames_o + 16'h0001;
	end
endmodule

`default_nettype wire

// file: async_serial_transmitter_tb_top.sv
// Self-checking bench of the serial transmitter over APB.
// Assumes astx_map.svh on the include path and a divisor of 2.
`include "astx_map.svh"
`default_nettype none

module async_serial_transmitter_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int D = 2;
	logic        mclk_i = 1'b0, rst_i = 1'b1, rx_full = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic        pready, pslverr, txd, tx_irq, rx_irq, r_stop;
	logic [2:0]  cfg = 3'h0;
	logic [8:0]  r_word;
	logic [15:0] r_frames, seen = 16'h0;
	logic [8:0]  exp_q[$];
	int          n_errors = 0, n_compared = 0, hi_run = 0;

	astx_tx #(.DIV_W(13)) uut (.mclk_i(mclk_i), .rst_i(rst_i),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .rx_full_i(rx_full),
		.txd_o(txd), .tx_irq_o(tx_irq), .rx_irq_o(rx_irq));
	astx_rx_model far (.mclk_i(mclk_i), .rst_i(rst_i), .line_i(txd),
		.div_i(13'(D)), .long_i(cfg[2]), .word_o(r_word),
		.stop_o(r_stop), .frames_o(r_frames));

	// Clock
	always #20 mclk_i = ~mclk_i;

	task automatic stop_test();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_rng(input int got, input int lo, input int hi);
		n_compared++;
		if (got < lo || got > hi) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask

	task automatic give_up();
		chk(32'h0, 32'h1);
		stop_test();
	endtask

	// One APB transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int k;
		k = 0;
		@(posedge mclk_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk_i);
		penable <= 1'b1;
		do begin
			@(posedge mclk_i);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) give_up();
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		logic e;
		apb(1'b0, a, 32'h0, r, e);
	endtask

	function automatic logic [8:0] exp_word(input logic [8:0] d);
		logic p;
		if (cfg[2]) begin
			p = ^d[7:0] ^ cfg[0];
			return {cfg[1] ? p : d[8], d[7:0]};
		end
		p = ^d[6:0] ^ cfg[0];
		return {1'b0, cfg[1] ? p : d[7], d[6:0]};
	endfunction

	// Poll the empty flag, arm the clear, load one word
	task automatic send(input logic [8:0] d);
		logic [31:0] r;
		int          k;
		k = 0;
		do begin
			rd(`ASTX_OFF_STATUS_ONE, r);
			k++;
		end while (r[7] !== 1'b1 && k < 400);
		if (k >= 400) give_up();
		// Ninth bit only once the buffer is free
		wr(`ASTX_OFF_BUF_HIGH, {25'h0, d[8], 6'h00});
		wr(`ASTX_OFF_BUF_LOW, {24'h0, d[7:0]});
		exp_q.push_back(exp_word(d));
	endtask

	task automatic wait_line(input logic v, input int lim, output int n);
		n = 0;
		while (txd !== v && n < lim) begin
			@(posedge mclk_i);
			n++;
		end
	endtask

	task automatic wait_q();
		int k;
		k = 0;
		while (exp_q.size() != 0 && k < 3000) begin
			@(posedge mclk_i);
			k++;
		end
		if (k >= 3000) give_up();
	endtask

	task automatic restart(input logic [2:0] c, input logic [7:0] en);
		wr(`ASTX_OFF_ENABLE_CFG, 32'h0);
		cfg = c;
		wr(`ASTX_OFF_FRAME_CFG, {27'h0, c[2], 2'h0, c[1], c[0]});
		wr(`ASTX_OFF_ENABLE_CFG, {24'h0, en});
	endtask

	// Line high run length and received frame checks
	always @(posedge mclk_i) begin
		hi_run <= (txd === 1'b1) ? hi_run + 1 : 0;
		if (r_frames !== seen) begin
			seen <= r_frames;
			if (exp_q.size() == 0) begin
				chk(32'(r_frames), 32'(seen));
			end else begin
				chk(32'(r_word), 32'(exp_q.pop_front()));
				chk(32'(r_stop), 32'h1);
			end
		end
	end

	// Main sequence
	initial begin
		logic [31:0] r;
		logic        e;
		int          n, m;
		void'($urandom(59));
		repeat (20) @(posedge mclk_i);
		rst_i <= 1'b0;
		rd(`ASTX_OFF_STATUS_ONE, r);
		chk(r, 32'h80);
		chk(32'(tx_irq), 32'h0);
		apb(1'b0, 8'h1C, 32'h0, r, e);
		chk(r, 32'h0);
		chk(32'(e), 32'h1);
		wr(`ASTX_OFF_FRAME_CFG, 32'h0);
		send(9'h035);
		wr(`ASTX_OFF_ENABLE_CFG, 32'h08);
		wait_line(1'b0, 200, n);
		chk(n, 200);
		wr(`ASTX_OFF_BAUD_HIGH, 32'h01);
		wait_line(1'b0, 200, n);
		chk(n, 200);
		wr(`ASTX_OFF_BAUD_HIGH, 32'h00);
		wr(`ASTX_OFF_BAUD_LOW, D);
		wait_line(1'b0, 400, n);
		chk_rng(n, 316, 330);
		wait_q();
		wr(`ASTX_OFF_ENABLE_CFG, 32'h88);
		@(posedge mclk_i);
		chk(32'(tx_irq), 32'h1);
		send(9'h015);
		send(9'h02A);
		@(posedge mclk_i);
		chk(32'(tx_irq), 32'h0);
		m = 0;
		while (tx_irq !== 1'b1 && m < 400) begin
			@(posedge mclk_i);
			m++;
		end
		if (m >= 400) give_up();
		chk_rng(hi_run, 14, 20);
		wait_line(1'b0, 100, n);
		chk_rng(hi_run, 30, 34);
		wait_q();
		wr(`ASTX_OFF_BUF_LOW, 32'h55);
		repeat (700) @(posedge mclk_i);
		rd(`ASTX_OFF_STATUS_ONE, r);
		chk(r, 32'h80);
		restart(3'h4, 8'h00);
		send(9'h1A5);
		wr(`ASTX_OFF_ENABLE_CFG, 32'h08);
		wait_line(1'b0, 500, n);
		chk_rng(n, 348, 362);
		wait_q();
		for (int i = 0; i < 8; i++) begin
			restart(i[2:0], {i[1], 1'b0, i[0], 1'b0, 1'b1, 3'h0});
			rx_full <= 1'($urandom);
			send(9'($urandom));
			send(9'($urandom));
			chk(32'(rx_irq), 32'(rx_full & i[0]));
			wait_q();
		end
		stop_test();
	end
endmodule

`default_nettype wire
